// ===== verilog/reset_selector_pkg.sv
// Purpose: Constants for the extended reset selector.
// Assumes: 40 MHz clock.
// Notes: Long counts are scaled from a 1 ms tick.
// Contract
// RL1: Function one clears battery-backed data blocks.
// RL2: Function two swaps in stored user project.
// RL3: Extended entry needs hold over five seconds.
// RL4: Indicator lights once threshold passes held.
// RL5: Operator releases to run before selecting.
// RL6: One press picks one, two pick two.
// RL7: Indicator off, then one or two flashes.
// RL8: After twenty seconds, indicator on ten seconds.
// RL9: Function runs only on press in window.
// RL10: Short press or timeout gives ordinary reset.
// RL11: Low battery reports option error 2816/120/1.
// RL12: Ordinary reset restarts program into run.
// RL13: Switch debounced, presses counted on clean edges.
package reset_selector_pkg;
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned TICK_MS         = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned HOLD_THRESHOLD_MS = 5000;
   localparam int unsigned SELECT_MS       = 20000;
   localparam int unsigned CONFIRM_MS      = 10000;
   localparam int unsigned FLASH_MS        = 250;
   localparam int unsigned DEBOUNCE_MS     = 20;
   localparam logic [15:0] ERR_CODE        = 16'h0b00;
   localparam logic [7:0]  ERR_MODULE      = 8'h78;
   localparam logic [7:0]  ERR_NUMBER      = 8'h01;
   typedef enum logic [6:0] {
      ST_IDLE    = 7'b0000001,
      ST_HOLD    = 7'b0000010,
      ST_RELEASE = 7'b0000100,
      ST_SELECT  = 7'b0001000,
      ST_FLASH   = 7'b0010000,
      ST_CONFIRM = 7'b0100000,
      ST_DONE    = 7'b1000000
   } seq_state_e;
endpackage

// ===== verilog/switch_debounce.sv
// Purpose: Debounce of one switch contact on the millisecond tick.
// Assumes: Input synchronous to clk.
// Notes: Output changes only after a stable run of STABLE_TICKS.
module switch_debounce
   import reset_selector_pkg::*;
#(
   parameter int unsigned STABLE_TICKS = DEBOUNCE_MS
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic tick,
   input  wire logic raw,
   output logic      clean
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic        clean_ff;
   logic        nxt_clean;

   // RL13 stable run check.
   always_comb begin
      nxt_cnt   = cnt_ff;
      nxt_clean = clean_ff;
      if (raw == clean_ff) begin
         nxt_cnt = '0;
      end else if (tick) begin
         if (cnt_ff >= 16'(STABLE_TICKS - 1)) begin
            nxt_clean = raw;
            nxt_cnt   = '0;
         end else begin
            nxt_cnt = cnt_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff   <= '0;
         clean_ff <= 1'b0;
      end else begin
         cnt_ff   <= nxt_cnt;
         clean_ff <= nxt_clean;
      end
   end

   assign clean = clean_ff;
endmodule // switch_debounce

// ===== verilog/extended_reset_selector.sv
// Purpose: Timed front switch sequencer for ordinary and extended resets.
// Assumes: Switch and battery inputs synchronous to clk.
// Notes: Time constants are in ticks and can be shortened for simulation.
module extended_reset_selector
   import reset_selector_pkg::*;
#(
   parameter int unsigned TICK_LEN    = TICK_CYCLES,
   parameter int unsigned HOLD_TICKS  = HOLD_THRESHOLD_MS,
   parameter int unsigned SEL_TICKS   = SELECT_MS,
   parameter int unsigned CONF_TICKS  = CONFIRM_MS,
   parameter int unsigned FLASH_TICKS = FLASH_MS,
   parameter int unsigned DEB_TICKS   = DEBOUNCE_MS
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        momentary_reset_position,
   input  wire logic        stop_position,
   input  wire logic        battery_low,
   output logic             ack_indicator,
   output logic             erase_data_blocks,
   output logic             reload_project,
   output logic             controller_reset,
   output logic             controller_program_run,
   output logic             option_error,
   output logic [15:0]      error_code,
   output logic [7:0]       error_module,
   output logic [7:0]       error_number
);
   logic [25:0] div_ff;
   logic [25:0] nxt_div;
   logic        tick_ff;
   logic        nxt_tick;
   logic        sw;
   logic        sw_q_ff;
   logic        press;
   logic        release_edge;
   seq_state_e  st_ff;
   seq_state_e  nxt_st;
   logic [15:0] tmr_ff;
   logic [15:0] nxt_tmr;
   logic [1:0]  cnt_ff;
   logic [1:0]  nxt_cnt;
   logic [2:0]  ph_ff;
   logic [2:0]  nxt_ph;
   logic        ack_ff;
   logic        nxt_ack;
   logic        erase_ff;
   logic        nxt_erase;
   logic        reload_ff;
   logic        nxt_reload;
   logic        rst_ff;
   logic        nxt_rst;
   logic        run_ff;
   logic        nxt_run;
   logic        err_ff;
   logic        nxt_err;
   logic [15:0] code_ff;
   logic [15:0] nxt_code;
   logic [7:0]  modnum_ff;
   logic [7:0]  nxt_modnum;
   logic [7:0]  errnum_ff;
   logic [7:0]  nxt_errnum;

   // Millisecond tick divider.
   always_comb begin
      nxt_tick = 1'b0;
      nxt_div  = div_ff + 26'h1;
      if (div_ff >= 26'(TICK_LEN - 1)) begin
         nxt_div  = '0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
         sw_q_ff <= 1'b0;
      end else begin
         div_ff  <= nxt_div;
         tick_ff <= nxt_tick;
         sw_q_ff <= sw;
      end
   end

   // RL13 debounced switch.
   switch_debounce #(
      .STABLE_TICKS (DEB_TICKS)
   ) u_deb (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (tick_ff),
      .raw   (momentary_reset_position),
      .clean (sw)
   );

   assign press        = sw & ~sw_q_ff;
   assign release_edge = ~sw & sw_q_ff;

   // Sequencer next state.
   always_comb begin
      nxt_st     = st_ff;
      nxt_tmr    = tmr_ff;
      nxt_cnt    = cnt_ff;
      nxt_ph     = ph_ff;
      nxt_ack    = ack_ff;
      nxt_erase  = 1'b0;
      nxt_reload = 1'b0;
      nxt_rst    = 1'b0;
      nxt_run    = run_ff;
      if (tick_ff) begin
         nxt_tmr = tmr_ff + 16'h1;
      end
      unique case (st_ff)
         ST_IDLE: begin
            nxt_tmr = '0;
            nxt_ack = 1'b0;
            nxt_run = ~stop_position;
            if (press) begin
               nxt_st = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // RL10 short press gives ordinary reset.
            if (release_edge) begin
               nxt_st  = ST_DONE;
               nxt_rst = 1'b1;
            // RL3 hold threshold passed.
            end else if (tick_ff && tmr_ff >= 16'(HOLD_TICKS)) begin
               nxt_st = ST_RELEASE;
               // RL4 indicator on.
               nxt_ack = 1'b1;
            end
         end
         ST_RELEASE: begin
            // RL5 wait for return to run.
            if (!sw) begin
               nxt_st  = ST_SELECT;
               nxt_tmr = '0;
               nxt_cnt = '0;
            end
         end
         ST_SELECT: begin
            // RL6 count presses.
            if (press && cnt_ff != 2'd2) begin
               nxt_cnt = cnt_ff + 2'd1;
               // RL7 indicator off then flash.
               nxt_ack = 1'b0;
            end
            if (tick_ff && tmr_ff >= 16'(SEL_TICKS - 1)) begin
               nxt_st  = ST_FLASH;
               nxt_tmr = '0;
               nxt_ph  = '0;
               nxt_ack = 1'b0;
            end
         end
         ST_FLASH: begin
            // RL7 one or two flashes.
            if (tick_ff && tmr_ff >= 16'(FLASH_TICKS - 1)) begin
               nxt_tmr = '0;
               nxt_ph  = ph_ff + 3'd1;
               nxt_ack = ~ph_ff[0] && (ph_ff[2:1] < {1'b0, cnt_ff[1]} + 2'(cnt_ff != 2'd0)) &&
                         (cnt_ff != 2'd0);
               if (ph_ff == 3'd4) begin
                  nxt_st  = ST_CONFIRM;
                  // RL8 steady on for window.
                  nxt_ack = 1'b1;
               end
            end
         end
         ST_CONFIRM: begin
            // RL9 confirm press runs function.
            if (press && cnt_ff != 2'd0) begin
               // RL1 clear data blocks.
               nxt_erase  = (cnt_ff == 2'd1);
               // RL2 replace project.
               nxt_reload = (cnt_ff == 2'd2);
               nxt_rst    = 1'b1;
               nxt_st     = ST_DONE;
               nxt_ack    = 1'b0;
            end else if (tick_ff && tmr_ff >= 16'(CONF_TICKS - 1)) begin
               // RL10 timeout gives ordinary reset.
               nxt_rst = 1'b1;
               nxt_st  = ST_DONE;
               nxt_ack = 1'b0;
            end
         end
         ST_DONE: begin
            // RL12 automatic restart into run.
            nxt_run = ~stop_position;
            if (!sw) begin
               nxt_st = ST_IDLE;
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   // RL11 battery monitor.
   always_comb begin
      nxt_err    = err_ff | battery_low;
      nxt_code   = nxt_err ? ERR_CODE : 16'h0000;
      nxt_modnum = nxt_err ? ERR_MODULE : 8'h00;
      nxt_errnum = nxt_err ? ERR_NUMBER : 8'h00;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff     <= ST_IDLE;
         tmr_ff    <= '0;
         cnt_ff    <= '0;
         ph_ff     <= '0;
         ack_ff    <= 1'b0;
         erase_ff  <= 1'b0;
         reload_ff <= 1'b0;
         rst_ff    <= 1'b0;
         run_ff    <= 1'b0;
         err_ff    <= 1'b0;
         code_ff   <= '0;
         modnum_ff <= '0;
         errnum_ff <= '0;
      end else begin
         st_ff     <= nxt_st;
         tmr_ff    <= nxt_tmr;
         cnt_ff    <= nxt_cnt;
         ph_ff     <= nxt_ph;
         ack_ff    <= nxt_ack;
         erase_ff  <= nxt_erase;
         reload_ff <= nxt_reload;
         rst_ff    <= nxt_rst;
         run_ff    <= nxt_run;
         err_ff    <= nxt_err;
         code_ff   <= nxt_code;
         modnum_ff <= nxt_modnum;
         errnum_ff <= nxt_errnum;
      end
   end

   assign ack_indicator          = ack_ff;
   assign erase_data_blocks      = erase_ff;
   assign reload_project         = reload_ff;
   assign controller_reset       = rst_ff;
   assign controller_program_run = run_ff;
   assign option_error           = err_ff;
   assign error_code             = code_ff;
   assign error_module           = modnum_ff;
   assign error_number           = errnum_ff;

   // RL1 erase only from confirm.
   chk_erase_cause: assert property (@(posedge clk) disable iff (!rst_n) // RL1
      $rose(erase_data_blocks) |-> $past(st_ff) == ST_CONFIRM && cnt_ff == 2'd1)
      else $error("erase without confirm");
   // RL2 reload only on count two.
   chk_reload_cause: assert property (@(posedge clk) disable iff (!rst_n) // RL2
      reload_project |-> $past(st_ff) == ST_CONFIRM && cnt_ff == 2'd2 && controller_reset)
      else $error("reload without confirm");
   // RL3 no entry before threshold.
   chk_hold_entry: assert property (@(posedge clk) disable iff (!rst_n) // RL3
      (st_ff == ST_HOLD && nxt_st == ST_RELEASE) |-> tmr_ff >= 16'(HOLD_TICKS))
      else $error("early extended entry");
   // RL4 indicator on after threshold.
   chk_ack_on: assert property (@(posedge clk) disable iff (!rst_n) // RL4
      (st_ff == ST_HOLD && nxt_st == ST_RELEASE) |=> ack_indicator)
      else $error("indicator not on");
   // RL6 first press counts one.
   chk_press_count: assert property (@(posedge clk) disable iff (!rst_n) // RL6
      (st_ff == ST_SELECT && press && cnt_ff == 2'd0) |=> cnt_ff == 2'd1)
      else $error("press not counted");
   // RL7 indicator off after selection.
   chk_sel_off: assert property (@(posedge clk) disable iff (!rst_n) // RL7
      (st_ff == ST_SELECT && press) |=> !ack_indicator)
      else $error("indicator not off");
   // RL8 steady in window.
   chk_confirm_lit: assert property (@(posedge clk) disable iff (!rst_n) // RL8
      (st_ff == ST_CONFIRM && $past(st_ff) == ST_CONFIRM) |-> ack_indicator)
      else $error("window not lit");
   // RL10 short press resets.
   chk_short_reset: assert property (@(posedge clk) disable iff (!rst_n) // RL10
      (st_ff == ST_HOLD && release_edge) |=> controller_reset && !erase_data_blocks)
      else $error("short press no reset");
   // RL11 error latched with code.
   chk_batt_err: assert property (@(posedge clk) disable iff (!rst_n) // RL11
      battery_low |=> option_error && error_code == ERR_CODE && error_number == ERR_NUMBER)
      else $error("battery error missing");
   cov_short: cover property (@(posedge clk) disable iff (!rst_n)
      st_ff == ST_HOLD && release_edge);
   cov_erase: cover property (@(posedge clk) disable iff (!rst_n) erase_data_blocks);
   cov_reload: cover property (@(posedge clk) disable iff (!rst_n) reload_project);
endmodule // extended_reset_selector

// ===== verif/operator_model.sv
// Purpose: Operator at the front switch of the reset selector.
// Assumes: Switch moves a fixed small delay after a rising clock edge.
// Notes: Each press opens with one cycle of contact chatter.
module operator_model #(
   parameter int unsigned TICK_LEN = 4
) (
   input  wire logic clk,
   output logic      momentary_reset_position
);
   timeunit 1ns;
   timeprecision 1ps;

   initial momentary_reset_position = 1'b0;

   task automatic push(input int ticks);
      @(posedge clk) #2 momentary_reset_position = 1'b1;
      @(posedge clk) #2 momentary_reset_position = 1'b0;
      @(posedge clk) #2 momentary_reset_position = 1'b1;
      repeat (ticks * TICK_LEN) @(posedge clk);
   endtask

   task automatic let_go(input int ticks);
      @(posedge clk) #2 momentary_reset_position = 1'b0;
      repeat (ticks * TICK_LEN) @(posedge clk);
   endtask

   task automatic tap();
      push(4);
      let_go(4);
   endtask
endmodule // operator_model

// ===== verif/extended_reset_selector_test.sv
// Purpose: Self-checking bench for the extended reset selector.
// Assumes: Shortened tick, hold, select, confirm and debounce counts.
// Notes: Switch sequence cases run from a table, battery and stop checks by hand.
module extended_reset_selector_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TL = 4;
   localparam int HOLD = 10;
   localparam int CONF = 20;
   localparam int LIM = 6000;
   localparam int CEIL = 48000;

   typedef struct {
      int   hold;
      int   presses;
      bit   confirm;
      logic exp_erase;
      logic exp_reload;
   } case_row_s;

   logic        clk;
   logic        rst_n;
   logic        sw;
   logic        stop_position;
   logic        battery_low;
   logic        ack_indicator;
   logic        erase_data_blocks;
   logic        reload_project;
   logic        controller_reset;
   logic        controller_program_run;
   logic        option_error;
   logic [15:0] error_code;
   logic [7:0]  error_module;
   logic [7:0]  error_number;
   logic        ack_q;
   int          rises;
   int          n_erase;
   int          n_reload;
   int          n_reset;
   int          cycles;
   int          error_cnt;
   int          total_checks;
   case_row_s   rows [7] = '{'{8, 0, 0, 0, 0}, '{16, 1, 1, 1, 0}, '{16, 2, 1, 0, 1},
                             '{16, 3, 1, 0, 1}, '{16, 1, 0, 0, 0}, '{16, 2, 0, 0, 0},
                             '{16, 0, 1, 0, 0}};

   extended_reset_selector #(.TICK_LEN(TL), .HOLD_TICKS(HOLD), .SEL_TICKS(40),
      .CONF_TICKS(CONF), .DEB_TICKS(2)) dut_u (
      .clk                      (clk),
      .rst_n                    (rst_n),
      .momentary_reset_position (sw),
      .stop_position            (stop_position),
      .battery_low              (battery_low),
      .ack_indicator            (ack_indicator),
      .erase_data_blocks        (erase_data_blocks),
      .reload_project           (reload_project),
      .controller_reset         (controller_reset),
      .controller_program_run   (controller_program_run),
      .option_error             (option_error),
      .error_code               (error_code),
      .error_module             (error_module),
      .error_number             (error_number)
   );

   operator_model #(.TICK_LEN(TL)) op_u (
      .clk                      (clk),
      .momentary_reset_position (sw)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (ack_indicator === 1'b1 && ack_q === 1'b0) rises++;
      ack_q = ack_indicator;
      n_erase += (erase_data_blocks === 1'b1);
      n_reload += (reload_project === 1'b1);
      n_reset += (controller_reset === 1'b1);
      if (cycles == CEIL) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_for(input bit on_reset, input int n);
      int i;
      for (i = 0; i < LIM && (on_reset ? n_reset : rises) < n; i++) @(posedge clk);
      check(i < LIM, 1);
   endtask

   task automatic run_case(input case_row_s r);
      n_erase = 0;
      n_reload = 0;
      n_reset = 0;
      op_u.push(r.hold);
      #2;
      check(ack_indicator, r.hold > HOLD);
      op_u.let_go(2);
      if (r.hold > HOLD) begin
         repeat (r.presses) op_u.tap();
         #2;
         check(ack_indicator, r.presses == 0);
         rises = 0;
         wait_for(0, (r.presses > 2 ? 2 : r.presses) + 1);
         if (r.confirm) begin
            repeat (2 * TL) @(posedge clk);
            op_u.tap();
         end else begin
            repeat ((CONF - 2) * TL) @(posedge clk);
            #2;
            check({ack_indicator, n_reset[0]}, 2'b10);
         end
      end
      wait_for(1, 1);
      repeat (4) @(posedge clk);
      #2;
      check(n_erase, r.exp_erase);
      check(n_reload, r.exp_reload);
      check(n_reset, 1);
      check(controller_program_run, 1);
   endtask

   task automatic final_report();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      stop_position = 1'b0;
      battery_low = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      check({ack_indicator, erase_data_blocks, reload_project, controller_reset,
             option_error, error_code, error_module, error_number}, 0);
      @(posedge clk) #2 rst_n = 1'b1;
      foreach (rows[k]) run_case(rows[k]);
      battery_low = 1'b1;
      repeat (4) @(posedge clk);
      #2 battery_low = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      check(option_error, 1);
      check({error_code, error_module, error_number}, {16'h0b00, 8'h78, 8'h01});
      stop_position = 1'b1;
      repeat (8) @(posedge clk);
      #2;
      check(controller_program_run, 0);
      stop_position = 1'b0;
      repeat (8) @(posedge clk);
      #2;
      check(controller_program_run, 1);
      op_u.push(16);
      #2;
      check(ack_indicator, 1);
      rst_n = 1'b0;
      #2;
      check({ack_indicator, option_error}, 0);
      op_u.let_go(4);
      #2 rst_n = 1'b1;
      run_case(rows[0]);
      final_report();
   end
endmodule // extended_reset_selector_test
